// ---- design/cst_pkg.sv ----
`default_nettype none
package cst_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [3:0] CST_CTRL_OFS = 4'h0;
  localparam logic [3:0] CST_STAT_OFS = 4'h4;
  localparam logic [3:0] CST_ISTAT_OFS = 4'h8;
  localparam logic [3:0] CST_IMASK_OFS = 4'hC;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int CST_CTRL_PRE_LSB = 0;
  localparam int CST_CTRL_TOT_LSB = 2;
  localparam int CST_CTRL_EXIT_BIT = 4;
  localparam int CST_CTRL_RET_BIT = 5;
  localparam int CST_CTRL_W = 6;
  localparam logic [5:0] CST_CTRL_RST = 6'h00;

  // ------------------------------------------------------------
  // status register fields
  // ------------------------------------------------------------
  localparam int CST_STAT_INRANGE_BIT = 0;
  localparam int CST_STAT_FLAG_BIT = 1;
  localparam int CST_STAT_PRE_TO_BIT = 2;
  localparam int CST_STAT_TOT_TO_BIT = 3;
  localparam int CST_STAT_SUSP_BIT = 4;

  // ------------------------------------------------------------
  // interrupt status and mask fields
  // ------------------------------------------------------------
  localparam int CST_IRQ_TEMP_BIT = 0;
  localparam int CST_IRQ_PRE_BIT = 1;
  localparam int CST_IRQ_TOT_BIT = 2;
  localparam int CST_IRQ_W = 3;
  localparam logic [2:0] CST_IMASK_RST = 3'h0;

  // ------------------------------------------------------------
  // timeout select codes and timing
  // ------------------------------------------------------------
  localparam logic [1:0] CST_SEL_A = 2'h0;
  localparam logic [1:0] CST_SEL_B = 2'h1;
  localparam logic [1:0] CST_SEL_C = 2'h2;
  localparam logic [1:0] CST_SEL_OFF = 2'h3;
  localparam int CST_CLK_HZ = 100_000_000;
  localparam int CST_SEC_PER_MIN = 60;
  localparam int CST_SEC_PER_HR = 3600;
  localparam int CST_PRE_A_MIN = 40;
  localparam int CST_PRE_B_MIN = 60;
  localparam int CST_PRE_C_MIN = 80;
  localparam int CST_TOT_A_HR = 3;
  localparam int CST_TOT_B_HR = 4;
  localparam int CST_TOT_C_HR = 5;
  localparam int CST_TMR_W = 15;
  // full charge current on the scale input
  localparam logic [8:0] CST_SCALE_FULL = 9'h100;

  // charge states reported by the charge state machine
  typedef enum logic [2:0] {
    CST_CHG_PRECOND = 3'h0,
    CST_CHG_FAST = 3'h1,
    CST_CHG_TOPOFF = 3'h3,
    CST_CHG_EOC = 3'h2,
    CST_CHG_SUSPEND = 3'h6,
    CST_CHG_TEMP_FAULT = 3'h7,
    CST_CHG_TIME_FAULT = 3'h5,
    CST_CHG_DISABLED = 3'h4
  } cst_chg_t;

  // battery temperature tracking states
  typedef enum logic {
    CST_T_IN = 1'b0,
    CST_T_OUT = 1'b1
  } cst_temp_t;

endpackage : cst_pkg
`default_nettype wire

// ---- design/cst_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
// two flop synchroniser for asynchronous level inputs
module cst_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // first stage, read only by the second
  logic [W-1:0] meta_r;

  // both stages clear to zero under reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : cst_sync
`default_nettype wire

// ---- design/cst_safety_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
// one safety timer: counts ticks while running, flags its limit
module cst_safety_timer #(
  parameter int W = cst_pkg::CST_TMR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic off_i,
  input wire logic [W-1:0] limit_i,
  // result
  output logic expired_o
);
  if (W < 2) begin : g_width_chk
    $error("timer width too small");
  end

  // elapsed ticks of this run
  logic [W-1:0] cnt_r;

  // count up while running, restart when the run ends
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      cnt_r <= '0;
    end else if (tick_i && !off_i && cnt_r != limit_i) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  // expiry is sticky for the rest of the run
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !run_i) begin
      expired_o <= 1'b0;
    end else if (!off_i && cnt_r == limit_i) begin
      expired_o <= 1'b1;
    end
  end
endmodule : cst_safety_timer
`default_nettype wire

// ---- design/cst_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module cst_top #(
  // clock cycles per one second timer tick
  parameter int TICK_CYCLES = cst_pkg::CST_CLK_HZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // charge state machine, same clock
  input wire logic [2:0] charge_state_i,
  input wire logic thermreg_active_i,
  input wire logic [7:0] thermreg_scale_i,
  // thermistor comparators, asynchronous
  input wire logic thermistor_sense_hot_i,
  input wire logic thermistor_sense_cold_i,
  // charger control
  output logic precond_timeout_o,
  output logic total_timeout_o,
  output logic charge_suspend_o,
  // open-drain charge indicator
  output logic charge_indicator_n_o,
  output logic charge_indicator_n_oe_n_o,
  // interrupt
  output logic irq_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (TICK_CYCLES < 2) begin : g_tick_chk
    $error("TICK_CYCLES must be at least 2");
  end

  // ------------------------------------------------------------
  // period decode
  // ------------------------------------------------------------
  localparam int TW = cst_pkg::CST_TMR_W;

  // precondition period in seconds
  function automatic logic [TW-1:0] pre_limit(input logic [1:0] s);
    logic [TW-1:0] v;
    v = TW'(cst_pkg::CST_PRE_A_MIN * cst_pkg::CST_SEC_PER_MIN);
    unique case (s)
      cst_pkg::CST_SEL_B:
        v = TW'(cst_pkg::CST_PRE_B_MIN * cst_pkg::CST_SEC_PER_MIN);
      cst_pkg::CST_SEL_C:
        v = TW'(cst_pkg::CST_PRE_C_MIN * cst_pkg::CST_SEC_PER_MIN);
      default: ;
    endcase
    return v;
  endfunction : pre_limit

  // total charge period in seconds
  function automatic logic [TW-1:0] tot_limit(input logic [1:0] s);
    logic [TW-1:0] v;
    v = TW'(cst_pkg::CST_TOT_A_HR * cst_pkg::CST_SEC_PER_HR);
    unique case (s)
      cst_pkg::CST_SEL_B:
        v = TW'(cst_pkg::CST_TOT_B_HR * cst_pkg::CST_SEC_PER_HR);
      cst_pkg::CST_SEL_C:
        v = TW'(cst_pkg::CST_TOT_C_HR * cst_pkg::CST_SEC_PER_HR);
      default: ;
    endcase
    return v;
  endfunction : tot_limit

  // ------------------------------------------------------------
  // registers and internal signals
  // ------------------------------------------------------------
  // control: selects and temperature event enables
  logic [5:0] ctrl_r;
  // sticky interrupt status, write one to clear
  logic [2:0] istat_r;
  // interrupt mask, one lets a bit through
  logic [2:0] imask_r;
  // temperature event flag, clear on read
  logic temp_event_flag_r;
  // temperature tracking state
  cst_pkg::cst_temp_t temp_st_r;
  // bus handshake
  logic waitreq_r;
  logic [31:0] rdata_r;
  // tick generation
  logic [31:0] presc_r;
  logic [8:0] acc_r;
  logic sec_r;
  logic tick_r;
  // synchronised comparators
  logic [1:0] th_s;
  // decoded fields
  logic [1:0] precond_timeout_sel;
  logic [1:0] total_timeout_sel;
  logic temp_exit_irq_en;
  logic temp_return_irq_en;
  logic temp_in_range;
  // events
  logic ev_exit;
  logic ev_return;
  logic ev_temp;
  logic pre_exp;
  logic tot_exp;
  logic pre_exp_d_r;
  logic tot_exp_d_r;
  logic [2:0] ev_irq;
  // bus decode
  logic rd_cap;
  logic wr_take;
  logic wr_lane0;
  // charge state decode
  cst_pkg::cst_chg_t chg_st;
  logic chg_active;
  logic run_pre;

  assign precond_timeout_sel = ctrl_r[cst_pkg::CST_CTRL_PRE_LSB +: 2];
  assign total_timeout_sel = ctrl_r[cst_pkg::CST_CTRL_TOT_LSB +: 2];
  assign temp_exit_irq_en = ctrl_r[cst_pkg::CST_CTRL_EXIT_BIT];
  assign temp_return_irq_en = ctrl_r[cst_pkg::CST_CTRL_RET_BIT];

  // ------------------------------------------------------------
  // comparator synchroniser
  // ------------------------------------------------------------
  cst_sync #(
    .W(2)
  ) u_th_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({thermistor_sense_cold_i, thermistor_sense_hot_i}),
    .q_o(th_s)
  );

  // inside range only while neither threshold is crossed
  assign temp_in_range = ~(th_s[0] | th_s[1]);

  // ------------------------------------------------------------
  // charge state decode
  // ------------------------------------------------------------
  assign chg_st = cst_pkg::cst_chg_t'(charge_state_i);

  // active charging: precondition, fast-charge, top-off
  assign chg_active = (chg_st == cst_pkg::CST_CHG_PRECOND)
                   || (chg_st == cst_pkg::CST_CHG_FAST)
                   || (chg_st == cst_pkg::CST_CHG_TOPOFF);
  assign run_pre = (chg_st == cst_pkg::CST_CHG_PRECOND);

  // ------------------------------------------------------------
  // timer tick, stretched under thermal regulation
  // ------------------------------------------------------------
  // one pulse per second of wall time
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      presc_r <= 32'h0000_0000;
      sec_r <= 1'b0;
    end else if (presc_r == 32'(TICK_CYCLES - 1)) begin
      presc_r <= 32'h0000_0000;
      sec_r <= 1'b1;
    end else begin
      presc_r <= presc_r + 32'h0000_0001;
      sec_r <= 1'b0;
    end
  end

  // each second adds the current fraction; a whole unit ticks
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_r <= 9'h000;
      tick_r <= 1'b0;
    end else if (sec_r) begin
      if (!thermreg_active_i) begin
        acc_r <= 9'h000;
        tick_r <= 1'b1;
      end else if ((10'(acc_r) + 10'(thermreg_scale_i))
                   >= 10'(cst_pkg::CST_SCALE_FULL)) begin
        acc_r <= 9'((10'(acc_r) + 10'(thermreg_scale_i))
                    - 10'(cst_pkg::CST_SCALE_FULL));
        tick_r <= 1'b1;
      end else begin
        acc_r <= acc_r + 9'(thermreg_scale_i);
        tick_r <= 1'b0;
      end
    end else begin
      tick_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // safety timers
  // ------------------------------------------------------------
  // precondition timer runs only in precondition
  cst_safety_timer #(
    .W(TW)
  ) u_pre_tmr (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(run_pre),
    .tick_i(tick_r),
    .off_i(precond_timeout_sel == cst_pkg::CST_SEL_OFF),
    .limit_i(pre_limit(precond_timeout_sel)),
    .expired_o(pre_exp)
  );

  // total timer runs across the whole active charge
  cst_safety_timer #(
    .W(TW)
  ) u_tot_tmr (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(chg_active),
    .tick_i(tick_r),
    .off_i(total_timeout_sel == cst_pkg::CST_SEL_OFF),
    .limit_i(tot_limit(total_timeout_sel)),
    .expired_o(tot_exp)
  );

  // timeout requests to the charge state machine
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      precond_timeout_o <= 1'b0;
      total_timeout_o <= 1'b0;
      pre_exp_d_r <= 1'b0;
      tot_exp_d_r <= 1'b0;
    end else begin
      precond_timeout_o <= pre_exp;
      total_timeout_o <= tot_exp;
      pre_exp_d_r <= pre_exp;
      tot_exp_d_r <= tot_exp;
    end
  end

  // ------------------------------------------------------------
  // charge indicator and temperature suspend
  // ------------------------------------------------------------
  // pin level held low; enable low means the pin is sunk
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      charge_indicator_n_o <= 1'b0;
      charge_indicator_n_oe_n_o <= 1'b1;
    end else begin
      charge_indicator_n_o <= 1'b0;
      charge_indicator_n_oe_n_o <= ~chg_active;
    end
  end

  // suspend charging while out of range
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      charge_suspend_o <= 1'b0;
    end else begin
      charge_suspend_o <= ~temp_in_range;
    end
  end

  // ------------------------------------------------------------
  // temperature tracking and events
  // ------------------------------------------------------------
  assign ev_exit = (temp_st_r == cst_pkg::CST_T_IN) && !temp_in_range;
  assign ev_return = (temp_st_r == cst_pkg::CST_T_OUT) && temp_in_range;
  assign ev_temp = (ev_exit && temp_exit_irq_en)
                || (ev_return && temp_return_irq_en);

  // follow the range; starts inside so a cold start out flags
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      temp_st_r <= cst_pkg::CST_T_IN;
    end else begin
      unique case (temp_st_r)
        cst_pkg::CST_T_IN: begin
          if (!temp_in_range) temp_st_r <= cst_pkg::CST_T_OUT;
        end
        cst_pkg::CST_T_OUT: begin
          if (temp_in_range) temp_st_r <= cst_pkg::CST_T_IN;
        end
      endcase
    end
  end

  // event flag: set wins over the clearing read
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      temp_event_flag_r <= 1'b0;
    end else if (ev_temp) begin
      temp_event_flag_r <= 1'b1;
    end else if (rd_cap && avs_address_i == cst_pkg::CST_STAT_OFS) begin
      temp_event_flag_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt status, mask and output
  // ------------------------------------------------------------
  assign ev_irq = {tot_exp && !tot_exp_d_r,
                   pre_exp && !pre_exp_d_r,
                   ev_temp};

  // sticky bits, write one clears, new event wins
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      istat_r <= 3'h0;
    end else if (wr_lane0
                 && avs_address_i == cst_pkg::CST_ISTAT_OFS) begin
      istat_r <= (istat_r & ~avs_writedata_i[2:0]) | ev_irq;
    end else begin
      istat_r <= istat_r | ev_irq;
    end
  end

  // level interrupt while any unmasked bit is set
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(istat_r & imask_r);
    end
  end

  // ------------------------------------------------------------
  // avalon-mm slave
  // ------------------------------------------------------------
  // first edge of a read captures data and side effects
  assign rd_cap = avs_read_i && waitreq_r;
  // a write lands where waitrequest is seen low
  assign wr_take = avs_write_i && !waitreq_r;
  assign wr_lane0 = wr_take && avs_byteenable_i[0];

  // one wait state per access, then back high
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      waitreq_r <= 1'b1;
    end else if (waitreq_r && (avs_read_i || avs_write_i)) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  assign avs_waitrequest_o = waitreq_r;

  // control register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_r <= cst_pkg::CST_CTRL_RST;
    end else if (wr_lane0 && avs_address_i == cst_pkg::CST_CTRL_OFS) begin
      ctrl_r <= avs_writedata_i[5:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      imask_r <= cst_pkg::CST_IMASK_RST;
    end else if (wr_lane0
                 && avs_address_i == cst_pkg::CST_IMASK_OFS) begin
      imask_r <= avs_writedata_i[2:0];
    end
  end

  // read mux, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_cap) begin
      rdata_r <= 32'h0000_0000;
      unique case (avs_address_i)
        cst_pkg::CST_CTRL_OFS: rdata_r[5:0] <= ctrl_r;
        cst_pkg::CST_STAT_OFS: begin
          rdata_r[cst_pkg::CST_STAT_INRANGE_BIT] <= temp_in_range;
          rdata_r[cst_pkg::CST_STAT_FLAG_BIT] <= temp_event_flag_r;
          rdata_r[cst_pkg::CST_STAT_PRE_TO_BIT] <= pre_exp;
          rdata_r[cst_pkg::CST_STAT_TOT_TO_BIT] <= tot_exp;
          rdata_r[cst_pkg::CST_STAT_SUSP_BIT] <= ~temp_in_range;
        end
        cst_pkg::CST_ISTAT_OFS: rdata_r[2:0] <= istat_r;
        cst_pkg::CST_IMASK_OFS: rdata_r[2:0] <= imask_r;
        default: ;
      endcase
    end
  end

  assign avs_readdata_o = rdata_r;

endmodule : cst_top
`default_nettype wire

// ---- bench/cst_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// port checker of the charger supervisor
// ------------------------------------------------------------
module cst_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // charger side
  input wire logic [2:0] charge_state_i,
  input wire logic thermistor_sense_hot_i,
  input wire logic thermistor_sense_cold_i,
  input wire logic precond_timeout_o,
  input wire logic total_timeout_o,
  input wire logic charge_suspend_o,
  input wire logic charge_indicator_n_o,
  input wire logic charge_indicator_n_oe_n_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic act; // an active charging state
  logic bad; // thermistor out of range
  assign act = charge_state_i inside {3'h0, 3'h1, 3'h3};
  assign bad = thermistor_sense_hot_i | thermistor_sense_cold_i;
  // one wait cycle, then the answer
  wait_one_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("answer held longer than one cycle");
  ans_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without a request");
  rd_unmap_a: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  rd_upper_a: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:6] == 26'h0) else $error("unused read bits set");
  ind_sink_a: assert property ($past(nrst_i) |-> charge_indicator_n_oe_n_o == !$past(act))
    else $error("indicator enable wrong for state");
  ind_level_a: assert property (charge_indicator_n_o == 1'b0)
    else $error("indicator pin level not low");
  temp_susp_a: assert property (bad [*5] |-> charge_suspend_o)
    else $error("no suspend while out of range");
  temp_resume_a: assert property (!bad [*5] |-> !charge_suspend_o)
    else $error("suspend while in range");
  pre_idle_a: assert property ((charge_state_i != 3'h0) [*5] |-> !precond_timeout_o)
    else $error("precondition expiry outside precondition");
  tot_idle_a: assert property (!act [*5] |-> !total_timeout_o)
    else $error("total expiry while not charging");
  cover property ($rose(precond_timeout_o));
  cover property ($rose(total_timeout_o));
  cover property ($rose(irq_o));
  cover property ($rose(charge_suspend_o));
endmodule : cst_chk
bind cst_top cst_chk u_cst_chk (.clk_i, .nrst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .charge_state_i,
  .thermistor_sense_hot_i, .thermistor_sense_cold_i, .precond_timeout_o,
  .total_timeout_o, .charge_suspend_o, .charge_indicator_n_o,
  .charge_indicator_n_oe_n_o, .irq_o);
`default_nettype wire

// ---- bench/cst_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// host software model: avalon-mm master
// ------------------------------------------------------------
module cst_host (
  // clock
  input wire logic clk_i,
  // master side of the register bus
  output logic [3:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  bit tmo = 1'b0; // set once a slave never answered
  initial begin
    avs_address_o = 4'h0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
    avs_byteenable_o = 4'h0;
  end
  // one access, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    bit wt;
    int n;
    wt = 1'b1;
    n = 0;
    q = 32'h0;
    @(posedge clk_i);
    avs_address_o <= a;
    avs_read_o <= !w;
    avs_write_o <= w;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    // sample at the rising edge, before the slave updates its flops
    while (wt && n < 64) begin
      @(posedge clk_i);
      wt = avs_waitrequest_i;
      q = avs_readdata_i;
      n++;
    end
    tmo = tmo | wt;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    // released address and data lines do not keep the last value
    avs_address_o <= ~a;
    avs_writedata_o <= ~d;
  endtask : xfer
endmodule : cst_host
`default_nettype wire

// ---- bench/tb_cst_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_cst_top;
  localparam int T = 2; // clocks per timer second, shortened
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] adr;
  logic rdq;
  logic wrq;
  logic [31:0] wdat;
  logic [3:0] be;
  logic [31:0] rdat;
  logic wreq;
  logic [2:0] cstate = 3'h4;
  logic treg = 1'b0;
  logic [7:0] tscale = 8'h0;
  logic hot = 1'b0;
  logic cold = 1'b0;
  logic pre_to, tot_to, susp, ind, ind_oe_n, irq;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h58299CB5;
  logic [31:0] q;
  // ------------------------------------------------------------
  // clock, design and host
  // ------------------------------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  cst_top #(.TICK_CYCLES(T)) u_cst_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .avs_address_i(adr), .avs_read_i(rdq), .avs_write_i(wrq),
    .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .charge_state_i(cstate),
    .thermreg_active_i(treg), .thermreg_scale_i(tscale),
    .thermistor_sense_hot_i(hot), .thermistor_sense_cold_i(cold),
    .precond_timeout_o(pre_to), .total_timeout_o(tot_to),
    .charge_suspend_o(susp), .charge_indicator_n_o(ind),
    .charge_indicator_n_oe_n_o(ind_oe_n), .irq_o(irq));
  cst_host u_cst_host (.clk_i(clk_i), .avs_address_o(adr),
    .avs_read_o(rdq), .avs_write_o(wrq), .avs_writedata_o(wdat),
    .avs_byteenable_o(be), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wreq));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected expiry in clocks from select code and current scale
  function automatic int exp_cyc(input logic [1:0] s, input logic t,
    input logic [7:0] sc);
    int b;
    b = t ? (3 + s) * 3600 : (40 + 20 * s) * 60;
    return (sc == 8'h0) ? b * T : b * T * 256 / sc;
  endfunction : exp_cyc
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
    u_cst_host.xfer(w, a, d, 4'hF, q);
    if (u_cst_host.tmo) begin
      err_total++;
      print_verdict();
    end
  endtask : rw
  // one timer run: restart timers, charge in state st, await expiry
  task automatic run_tmr(input logic [5:0] c, input logic [2:0] st,
    input logic [7:0] sc, input int n, input logic e, input logic t);
    int k;
    cyc(1);
    cstate <= 3'h4;
    rw(1'b1, cst_pkg::CST_CTRL_OFS, {26'h0, c});
    treg <= (sc != 8'h0);
    tscale <= sc;
    cstate <= st;
    cyc(n - 12);
    @(negedge clk_i);
    chk_bit(t ? tot_to : pre_to, 1'b0);
    k = 0;
    while (!(t ? tot_to : pre_to) && k < 24) begin
      @(negedge clk_i);
      k++;
    end
    chk_bit(t ? tot_to : pre_to, e);
    chk_bit(tot_to, t & e);
    rw(1'b0, cst_pkg::CST_STAT_OFS, 32'h0);
    chk_reg(q & 32'hC, {28'h0, t & e, !t & e, 2'h0});
    $display("timer run sel %0h done", c[3:0]);
  endtask : run_tmr
  // move thermistor inputs and let them settle
  task automatic temp(input logic h, input logic c);
    cyc(1);
    hot <= h;
    cold <= c;
    cyc(8);
    @(negedge clk_i);
    chk_bit(susp, h | c);
  endtask : temp
  // ------------------------------------------------------------
  // watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
  initial begin
    cyc(12);
    nrst_i <= 1'b1;
    cyc(2);
    rw(1'b0, cst_pkg::CST_CTRL_OFS, 32'h0);
    chk_reg(q, {26'h0, cst_pkg::CST_CTRL_RST});
    rw(1'b0, cst_pkg::CST_IMASK_OFS, 32'h0);
    chk_reg(q, {29'h0, cst_pkg::CST_IMASK_RST});
    rw(1'b0, 4'h2, 32'h0);
    chk_reg(q, 32'h0);
    // random control values and every charge state
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rw(1'b1, cst_pkg::CST_CTRL_OFS, seed);
      u_cst_host.xfer(1'b1, cst_pkg::CST_CTRL_OFS, ~seed, 4'hE, q);
      rw(1'b0, cst_pkg::CST_CTRL_OFS, 32'h0);
      chk_reg(q, {26'h0, seed[5:0]});
      cstate <= i[2:0];
      cyc(2);
      @(negedge clk_i);
      chk_bit(ind_oe_n, !(i inside {0, 1, 3}));
      chk_bit(ind, 1'b0);
    end
    $display("register and indicator test done");
    for (int s = 0; s < 3; s++) begin
      run_tmr({4'h3, s[1:0]}, 3'h0, 8'h00,
              exp_cyc(s[1:0], 1'b0, 8'h00), 1'b1, 1'b0);
    end
    run_tmr(6'h0F, 3'h0, 8'h0, 5000, 1'b0, 1'b0);
    run_tmr(6'h0C, 3'h0, 8'h80, exp_cyc(2'h0, 1'b0, 8'h80), 1'b1,
            1'b0);
    run_tmr(6'h03, 3'h1, 8'h00, exp_cyc(2'h0, 1'b1, 8'h00), 1'b1,
            1'b1);
    cstate <= 3'h4;
    rw(1'b1, cst_pkg::CST_CTRL_OFS, 32'h3F);
    rw(1'b1, cst_pkg::CST_IMASK_OFS, 32'h1);
    rw(1'b1, cst_pkg::CST_ISTAT_OFS, 32'h7);
    temp(1'b1, 1'b0);
    chk_bit(irq, 1'b1);
    rw(1'b0, cst_pkg::CST_STAT_OFS, 32'h0);
    chk_reg(q & 32'h13, 32'h12);
    rw(1'b0, cst_pkg::CST_STAT_OFS, 32'h0);
    chk_reg(q & 32'h2, 32'h0);
    rw(1'b1, cst_pkg::CST_ISTAT_OFS, 32'h1);
    cyc(2);
    @(negedge clk_i);
    chk_bit(irq, 1'b0);
    temp(1'b0, 1'b0);
    rw(1'b0, cst_pkg::CST_STAT_OFS, 32'h0);
    chk_reg(q & 32'h13, 32'h03);
    rw(1'b1, cst_pkg::CST_ISTAT_OFS, 32'h1);
    rw(1'b1, cst_pkg::CST_CTRL_OFS, 32'h0F);
    temp(1'b0, 1'b1);
    chk_bit(irq, 1'b0);
    rw(1'b0, cst_pkg::CST_STAT_OFS, 32'h0);
    chk_reg(q & 32'h13, 32'h10);
    temp(1'b0, 1'b0);
    rw(1'b0, cst_pkg::CST_STAT_OFS, 32'h0);
    chk_reg(q & 32'h13, 32'h01);
    rw(1'b1, cst_pkg::CST_CTRL_OFS, 32'h3F);
    rw(1'b1, cst_pkg::CST_IMASK_OFS, 32'h0);
    temp(1'b1, 1'b0);
    chk_bit(irq, 1'b0);
    rw(1'b0, cst_pkg::CST_ISTAT_OFS, 32'h0);
    chk_reg(q & 32'h1, 32'h1);
    rw(1'b1, cst_pkg::CST_ISTAT_OFS, 32'h1);
    rw(1'b0, cst_pkg::CST_ISTAT_OFS, 32'h0);
    chk_reg(q & 32'h1, 32'h0);
    $display("temperature test done");
    print_verdict();
  end
endmodule : tb_cst_top
`default_nettype wire
